// ===== pkg/plac_pkg.sv
/*
  Shared constants and types for the port loopback and AIS control block.
  Assumes a single 250 MHz core clock shared by all users of this package.
*/
`default_nettype none
package plac_pkg;
  typedef enum logic [1:0] {FM_DS3 = 2'b00, FM_E3 = 2'b01, FM_CLEAR = 2'b10} plac_fm_t;
  // zero-substituting coding is the hdb3 / b3zs family
  typedef enum logic [1:0] {LC_UNIPOLAR = 2'b00, LC_AMI = 2'b01, LC_ZSUB = 2'b10} plac_code_t;
  typedef enum logic [1:0] {LA_IDLE = 2'b00, LA_ONES = 2'b01, LA_FRAMED = 2'b10} plac_la_t;
  // loopback select codes; bit 2 alone marks diagnostic
  localparam logic [2:0] LBS_ANALOG = 3'h1;
  localparam logic [2:0] LBS_LINE = 3'h2;
  localparam logic [2:0] LBS_PAYLOAD = 3'h3;
  localparam logic [2:0] LBS_BOTH = 3'h6;
  // line ais select codes; 2'h3 disables
  localparam logic [1:0] LAS_AUTO = 2'h0;
  localparam logic [1:0] LAS_ONES = 2'h1;
  localparam logic [1:0] LAS_SEND = 2'h2;
  // payload ais select codes
  localparam logic [2:0] PAS_ALWAYS = 3'h0;
  localparam logic [2:0] PAS_LLB = 3'h1;
  localparam logic [2:0] PAS_PLB = 3'h2;
  localparam logic [2:0] PAS_LOOP = 3'h3;
  localparam logic [2:0] PAS_LOS = 3'h4;
  localparam logic [2:0] PAS_OOF = 3'h5;
  localparam logic [2:0] PAS_ANY = 3'h6;
  localparam logic [2:0] PAYLOAD_AIS_SELECT_SEL_RESET = PAS_ALWAYS;
  // ds3 m-frame: 7 subframes of 8 blocks of 1 overhead + 84 payload bits
  localparam int DS3_BLOCK_BITS = 85;
  localparam int DS3_BLOCKS = 8;
  localparam int DS3_SUBFRAMES = 7;
  localparam int CLK_MHZ = 250;
  localparam int OOF_PERSIST_US = 2500;
  localparam int OOF_PERSIST_CYCLES = OOF_PERSIST_US * CLK_MHZ;
  localparam int AIS_DETECT_BITS = 1024;
endpackage
`default_nettype wire

// ===== pkg/plac_stream_if.sv
/*
  Valid/ready bit stream carrier between the port controller and its buffer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface plac_stream_if #(parameter int W = 1);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// ===== rtl/plac_skid_buf.sv
/*
  Small FIFO on the receive payload path; depth 2 absorbs one stall cycle.
  Assumes DEPTH is a power of two and both sides share clk.
*/
`timescale 1ns/1ps
`default_nettype none
module plac_skid_buf #(
  parameter int W = 1,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // streams
  plac_stream_if.snk up,
  plac_stream_if.src dn
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr_reg;
  logic [PW-1:0] rdPtr_reg;
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic ready_reg;
  logic valid_reg;
  logic accIn;
  logic accOut;

  assign accIn = up.valid & ready_reg;
  assign accOut = valid_reg & dn.ready;
  assign count_next = count_reg + CW'(accIn) - CW'(accOut);

  always_ff @(posedge clk) begin
    if (accIn) begin
      mem[wrPtr_reg] <= up.data;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
      ready_reg <= 1'b0;
      valid_reg <= 1'b0;
    end else begin
      if (accIn) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (accOut) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
      count_reg <= count_next;
      // registered flags keep both handshakes free of combinational paths
      ready_reg <= count_next != CW'(DEPTH);
      valid_reg <= count_next != '0;
    end
  end

  assign up.ready = ready_reg;
  assign dn.valid = valid_reg;
  assign dn.data = mem[rdPtr_reg];
endmodule
`default_nettype wire

// ===== rtl/plac_port_ctrl.sv
/*
  Per-port loopback selection, loss-of-signal gating and AIS generation
  and detection for one ds3/e3/clear-channel port.
  Assumes framer, line coder and cell processors sit on clk and give one
  bit per strobe; line pins and overhead mask pins are asynchronous.
*/
// Functional notes
// RL1: decode loopback select into four loopbacks
// RL2: system loopback has its own bit
// RL3: no analog loopback while loop timing
// RL4: analog loop via interface unit or pins
// RL5: line loopback returns resampled receive data
// RL6: optional payload ais in line loopback
// RL7: payload loopback copies receive payload outward
// RL8: payload loopback gates frame start, enables, cells
// RL9: diagnostic loop returns pre-encoding transmit data
// RL10: top line ais in diagnostic, not line
// RL11: system loopback drops cells from line
// RL12: loss of signal only in zero-substituting coding
// RL13: loss feed dead in diagnostic loopback
// RL14: ds3 framed ais pattern, all ones elsewhere
// RL15: framer ais inserted before encoding
// RL16: top ds3 ais keeps its own alignment
// RL17: software stages framer ais before top
// RL18: framer ais loops out, top does not
// RL19: receive ais detect, framed only in ds3
// RL20: payload ais select resets to always
// RL21: framer ais waits 2.5 ms oof; code waits only in ds3 and follows oof at once in other modes
// RL22: ais activation sources per generator
// RL23: overhead mask pauses and masks ais
// RL24: decode two-bit line ais select
// RL25: decode three-bit payload ais select
// RL26: loop timing takes receive clock source
`timescale 1ns/1ps
`default_nettype none
module plac_port_ctrl #(
  parameter int OOF_PERSIST_CYC = plac_pkg::OOF_PERSIST_CYCLES,
  parameter int AIS_DETECT_BITS = plac_pkg::AIS_DETECT_BITS
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // configuration
  input wire logic [2:0] loopbackSelect,
  input wire logic systemLoopback,
  input wire logic loopTimingEnable,
  input wire logic liuEnable,
  input wire plac_pkg::plac_fm_t framingModeSelect,
  input wire plac_pkg::plac_code_t lineCoding,
  input wire logic overheadMaskMode,
  input wire logic [1:0] lineAisSelect,
  input wire logic cfgLoad,
  input wire logic [2:0] payloadAisSelect,
  input wire logic plbForceDenZero,
  input wire logic plbHaltCells,
  input wire logic framerRxAisSw,
  // line pins and coder
  input wire logic rxLinePositive,
  input wire logic rxLineNegative,
  input wire logic txEncPositive,
  input wire logic txEncNegative,
  output logic txLinePositive,
  output logic txLineNegative,
  output logic rxDecPositive,
  output logic rxDecNegative,
  output logic liuAnalogLoop,
  output logic txClockFromRx,
  output logic txClockLoopTimed,
  output logic txClockRecovered,
  // transmit framer side
  input wire logic txBitStrobe,
  input wire logic txFramerData,
  input wire logic txFrameStartIn,
  input wire logic txOverheadMaskIn,
  input wire logic txDataEnableIn,
  output logic txLineData,
  output logic txDataEnableOut,
  output logic txFrameStartToFramer,
  output logic plbTxData,
  // receive framer side
  input wire logic rxBitStrobe,
  input wire logic rxDecData,
  input wire logic rxOverheadMaskIn,
  input wire logic rxFramerOhFlag,
  input wire logic losRaw,
  input wire logic oofIn,
  output logic rxFramerData,
  output logic rxFramerStrobe,
  output logic losStatus,
  output logic losToFramer,
  output logic aisDetected,
  output logic framerRxAis,
  // receive payload stream
  input wire logic rxPayloadData,
  input wire logic rxPayloadValid,
  output logic rxPayloadReady,
  output logic rxSerialOut,
  output logic rxSerialValid,
  input wire logic rxSerialReady,
  // cell processors and status
  output logic txCellHalt,
  output logic txCellDiscard,
  output logic rxLineCellDiscard,
  output logic sysLoopbackActive,
  output logic lbAnalog,
  output logic lbLine,
  output logic lbPayload,
  output logic lbDiag,
  output logic topPais
);
  import plac_pkg::*;

  localparam int OW = $clog2(OOF_PERSIST_CYC + 1);
  localparam int DW = $clog2(AIS_DETECT_BITS + 1);

  // returns {analog, line, payload, diagnostic}
  function automatic logic [3:0] lbDecode(input logic [2:0] sel);
    logic [3:0] r;
    r = 4'h0;
    case (sel)
      LBS_ANALOG: r = 4'h8;
      LBS_LINE: r = 4'h4;
      LBS_PAYLOAD: r = 4'h2;
      LBS_BOTH: r = 4'h5;
      default: r = {3'h0, sel[2]};
    endcase
    return r;
  endfunction

  // framed ais bit: x=1, p=0, m=010, f=1001, c=0, payload 1010 per block
  function automatic logic ds3AisBit(input logic [2:0] sf, input logic [2:0] blk,
                                     input logic [6:0] bi);
    logic r;
    r = bi[0];
    if (bi == 7'h00) begin
      case (blk)
        3'h0: r = (sf < 3'h2) | (sf == 3'h5);
        3'h1, 3'h7: r = 1'b1;
        default: r = 1'b0;
      endcase
    end
    return r;
  endfunction

  // pins: {rx pos, rx neg, frame start, tx mask, rx mask}
  logic [4:0] pinS1;
  logic [4:0] pinS2;
  logic [4:0] pinS3;
  logic [4:0] pinF;
  logic txSofD;
  logic [3:0] lbv;
  logic albN, llbN, plbN, dlbN, isDs3, pause, sofRise;
  plac_la_t laState;
  plac_la_t laWant;
  logic [6:0] bitIdx;
  logic [2:0] blkIdx;
  logic [2:0] sfIdx;
  logic detBit, detStb, detMask, expect_reg;
  logic [DW-1:0] onesCnt;
  logic [DW-1:0] altCnt;
  logic [OW-1:0] oofCnt;
  logic oofLong, losStat, losFeed, llbOnly, paisWant, haltN, framerPay;
  logic [2:0] paisSel_reg;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pinS1 <= 5'h00;
      pinS2 <= 5'h00;
      pinS3 <= 5'h00;
      pinF <= 5'h00;
      txSofD <= 1'b0;
    end else begin
      pinS1 <= {rxLinePositive, rxLineNegative, txFrameStartIn, txOverheadMaskIn,
                rxOverheadMaskIn};
      pinS2 <= pinS1;
      pinS3 <= pinS2;
      // a change counts only once two stages agree, filtering one-cycle glitches
      pinF <= (pinS2 & pinS3) | (pinF & (pinS2 | pinS3));
      txSofD <= pinF[2];
    end
  end

  always_comb begin
    lbv = lbDecode(loopbackSelect); // [RL1]
    albN = lbv[3] & ~loopTimingEnable; // [RL3]
    llbN = lbv[2];
    plbN = lbv[1] & ~overheadMaskMode; // [RL7]
    dlbN = lbv[0];
    isDs3 = framingModeSelect == FM_DS3;
    pause = overheadMaskMode & pinF[1]; // [RL23]
    sofRise = pinF[2] & ~txSofD;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lbAnalog <= 1'b0;
      lbLine <= 1'b0;
      lbPayload <= 1'b0;
      lbDiag <= 1'b0;
      sysLoopbackActive <= 1'b0;
      rxLineCellDiscard <= 1'b0;
      liuAnalogLoop <= 1'b0;
      txClockFromRx <= 1'b0;
      txClockLoopTimed <= 1'b0;
      txClockRecovered <= 1'b0;
    end else begin
      lbAnalog <= albN;
      lbLine <= llbN;
      lbPayload <= plbN;
      lbDiag <= dlbN;
      sysLoopbackActive <= systemLoopback; // [RL2] [RL11]
      rxLineCellDiscard <= systemLoopback; // [RL11]
      liuAnalogLoop <= albN & liuEnable; // [RL4]
      txClockFromRx <= llbN; // [RL5]
      txClockLoopTimed <= loopTimingEnable; // [RL26]
      txClockRecovered <= liuEnable; // [RL26]
    end
  end

  // line pins: line loopback retimes receive data, analog without the interface unit returns transmit pins
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      txLinePositive <= 1'b0;
      txLineNegative <= 1'b0;
      rxDecPositive <= 1'b0;
      rxDecNegative <= 1'b0;
    end else begin
      txLinePositive <= llbN ? pinF[4] : txEncPositive; // [RL5]
      txLineNegative <= llbN ? pinF[3] : txEncNegative; // [RL5]
      rxDecPositive <= (albN & ~liuEnable) ? txLinePositive : pinF[4]; // [RL4]
      rxDecNegative <= (albN & ~liuEnable) ? txLineNegative : pinF[3]; // [RL4]
    end
  end

  always_comb begin
    case (lineAisSelect) // [RL24]
      LAS_AUTO: laWant = dlbN ? (isDs3 ? LA_FRAMED : LA_ONES) : LA_IDLE; // [RL22]
      LAS_ONES: laWant = LA_ONES;
      LAS_SEND: laWant = isDs3 ? LA_FRAMED : LA_ONES; // [RL14]
      default: laWant = LA_IDLE;
    endcase
    if (llbN) begin
      laWant = LA_IDLE; // [RL10]
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      laState <= LA_IDLE;
    end else begin
      laState <= laWant;
    end
  end

  // frame position realigns only while idle, so a running ais never slips
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bitIdx <= 7'h00;
      blkIdx <= 3'h0;
      sfIdx <= 3'h0;
    end else if (laState == LA_IDLE && sofRise && !overheadMaskMode) begin
      bitIdx <= 7'h00; // [RL16] [RL17]
      blkIdx <= 3'h0;
      sfIdx <= 3'h0;
    end else if (txBitStrobe && !pause) begin
      bitIdx <= bitIdx + 7'h01;
      if (bitIdx == 7'(DS3_BLOCK_BITS - 1)) begin
        bitIdx <= 7'h00;
        blkIdx <= blkIdx + 3'h1;
        if (blkIdx == 3'(DS3_BLOCKS - 1)) begin
          blkIdx <= 3'h0;
          sfIdx <= (sfIdx == 3'(DS3_SUBFRAMES - 1)) ? 3'h0 : sfIdx + 3'h1;
        end
      end
    end
  end

  // ais goes in ahead of the encoder so coding stays violation free
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      txLineData <= 1'b0;
    end else if (txBitStrobe) begin
      case (laState)
        LA_ONES: txLineData <= 1'b1; // [RL15]
        LA_FRAMED: txLineData <= pause ? txFramerData : ds3AisBit(sfIdx, blkIdx, bitIdx); // [RL14]
        default: txLineData <= txFramerData;
      endcase
    end
  end

  // receive detector input follows the diagnostic loop
  always_comb begin
    detBit = dlbN ? txFramerData : rxDecData; // [RL9]
    detStb = dlbN ? txBitStrobe : rxBitStrobe;
    detMask = overheadMaskMode ? (dlbN ? pinF[1] : pinF[0]) : rxFramerOhFlag; // [RL23]
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rxFramerData <= 1'b0;
      rxFramerStrobe <= 1'b0;
      onesCnt <= '0;
      altCnt <= '0;
      expect_reg <= 1'b1;
      aisDetected <= 1'b0;
    end else begin
      rxFramerData <= detBit; // [RL9] [RL10]
      rxFramerStrobe <= detStb;
      if (detStb && detMask) begin
        expect_reg <= 1'b1;
      end else if (detStb) begin
        expect_reg <= ~expect_reg;
        if (!detBit) begin
          onesCnt <= '0;
        end else if (onesCnt != DW'(AIS_DETECT_BITS)) begin
          onesCnt <= onesCnt + 1'b1;
        end
        if (detBit != expect_reg) begin
          altCnt <= '0;
        end else if (altCnt != DW'(AIS_DETECT_BITS)) begin
          altCnt <= altCnt + 1'b1;
        end
      end
      aisDetected <= (onesCnt == DW'(AIS_DETECT_BITS)) |
                     (isDs3 & (altCnt == DW'(AIS_DETECT_BITS))); // [RL19]
    end
  end

  always_comb begin
    losStat = (lineCoding == LC_ZSUB) & losRaw; // [RL12]
    losFeed = losStat & ~dlbN; // [RL13]
    oofLong = oofCnt == OW'(OOF_PERSIST_CYC);
    llbOnly = llbN & ~dlbN; // [RL6]
    case (paisSel_reg) // [RL25]
      PAS_ALWAYS: paisWant = 1'b1;
      PAS_LLB: paisWant = llbOnly;
      PAS_PLB: paisWant = plbN;
      PAS_LOOP: paisWant = llbOnly | plbN;
      PAS_LOS: paisWant = losFeed;
      PAS_OOF: paisWant = oofIn; // [RL21]
      PAS_ANY: paisWant = llbOnly | plbN | losFeed | oofIn; // [RL22]
      default: paisWant = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      oofCnt <= '0;
      paisSel_reg <= PAYLOAD_AIS_SELECT_SEL_RESET; // [RL20]
      losStatus <= 1'b0;
      losToFramer <= 1'b0;
      framerRxAis <= 1'b0;
      topPais <= 1'b0;
    end else begin
      if (!oofIn) begin
        oofCnt <= '0;
      end else if (!oofLong) begin
        oofCnt <= oofCnt + 1'b1; // [RL21]
      end
      if (cfgLoad) begin
        paisSel_reg <= payloadAisSelect;
      end
      losStatus <= losStat; // [RL12]
      losToFramer <= losFeed; // [RL13]
      framerRxAis <= framerRxAisSw | aisDetected | losFeed | (isDs3 ? oofLong : oofIn); // [RL22]
      topPais <= paisWant;
    end
  end

  // framer ais rides the payload loop outward; top ais only goes downstream
  assign framerPay = framerRxAis | rxPayloadData;
  assign haltN = plbN & (framingModeSelect != FM_CLEAR) & plbHaltCells;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      plbTxData <= 1'b0;
      txCellHalt <= 1'b0;
      txCellDiscard <= 1'b0;
      txDataEnableOut <= 1'b0;
      txFrameStartToFramer <= 1'b0;
    end else begin
      plbTxData <= framerPay; // [RL7] [RL18]
      txCellHalt <= haltN; // [RL8]
      txCellDiscard <= plbN & ~haltN; // [RL8]
      txDataEnableOut <= txDataEnableIn & ~(plbN & plbForceDenZero); // [RL8]
      txFrameStartToFramer <= pinF[2] & ~plbN & ~overheadMaskMode; // [RL8]
    end
  end

  plac_stream_if #(.W(1)) inIf ();
  plac_stream_if #(.W(1)) outIf ();

  // all ones covers overhead positions too
  assign inIf.data = topPais | framerPay; // [RL6] [RL18] [RL23]
  assign inIf.valid = rxPayloadValid;
  assign outIf.ready = rxSerialReady;
  assign rxPayloadReady = inIf.ready;
  assign rxSerialOut = outIf.data;
  assign rxSerialValid = outIf.valid;

  plac_skid_buf #(.W(1), .DEPTH(2)) payBuf (
    .clk(clk),
    .reset_n(reset_n),
    .up(inIf.snk),
    .dn(outIf.src)
  );

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_alb_looptime: assert property (loopTimingEnable |=> !lbAnalog) // [RL3]
    else $error("analog loopback active under loop timing");
  a_slb_return: assert property (systemLoopback |=> rxLineCellDiscard && sysLoopbackActive) // [RL11]
    else $error("system loopback not discarding line cells");
  a_los_mode: assert property ((lineCoding != LC_ZSUB) |=> !losStatus) // [RL12]
    else $error("loss of signal reported outside zero-substituting coding");
  a_los_diag: assert property (lbDiag |-> !losToFramer) // [RL13]
    else $error("loss feed active in diagnostic loopback");
  a_plb_den: assert property (lbPayload && $past(plbForceDenZero) |-> !txDataEnableOut) // [RL8]
    else $error("data enable not forced low in payload loopback");
  a_llb_no_ais: assert property (lbLine |-> laState == LA_IDLE) // [RL10]
    else $error("top line ais running during line loopback");
  a_payload_ais_select_reset: assert property ($rose(reset_n) |-> paisSel_reg == PAS_ALWAYS) // [RL20]
    else $error("payload ais select not always after reset");
  a_oof_delay: assert property ($rose(oofIn) |=> !oofLong ##1 !oofLong) // [RL21]
    else $error("framer oof persistence ended too early");
  a_top_oof: assert property ((oofIn && paisSel_reg == PAS_OOF) |=> topPais) // [RL21]
    else $error("top payload ais late on oof");
  a_ds3_payload: assert property ((laState == LA_FRAMED && txBitStrobe && !pause &&
      bitIdx != 7'h00 && bitIdx != 7'h54) |=> txLineData == $past(bitIdx[0])) // [RL14]
    else $error("framed ais payload not alternating");
endmodule
`default_nettype wire

// ===== dv/plac_line_far_end.sv
/*
  Far-end line equipment model: drives the receive line pins of one port.
  Assumes the bench says when a signal is present and which marks to send.
*/
`timescale 1ns/1ps
`default_nettype none
module plac_line_far_end (
  // clock
  input wire logic clk,
  // bench control
  input wire logic farOn,
  input wire logic farP,
  input wire logic farN,
  // receive line pins
  output logic rxLinePositive,
  output logic rxLineNegative
);
  logic pinP = 1'b0;
  logic pinN = 1'b1;
  // with no carrier the pins toggle every cycle, so the port's glitch filter holds the last mark
  always_ff @(posedge clk) begin
    pinP <= farOn ? farP : ~pinP;
    pinN <= farOn ? farN : ~pinN;
  end
  assign rxLinePositive = pinP;
  assign rxLineNegative = pinN;
endmodule
`default_nettype wire

// ===== dv/port_loopback_ais_control_bench.sv
/*
  Self-checking bench for the port loopback and AIS controller.
  Assumes plac_pkg is compiled first and the far-end model drives the rx pins.
*/
`timescale 1ns/1ps
`default_nettype none
module port_loopback_ais_control_bench;
  import plac_pkg::*;
  localparam int OOF_CYC = 20;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] loopbackSelect = 3'h0, payloadAisSelect = 3'h0;
  logic [1:0] lineAisSelect = 2'h3;
  plac_fm_t framingModeSelect = FM_E3;
  plac_code_t lineCoding = LC_ZSUB;
  logic systemLoopback = 0, loopTimingEnable = 0, liuEnable = 0, overheadMaskMode = 0;
  logic cfgLoad = 0, plbForceDenZero = 0, plbHaltCells = 0, framerRxAisSw = 0;
  logic txEncPositive = 0, txEncNegative = 0, txBitStrobe = 0, txFramerData = 0;
  logic txFrameStartIn = 0, txOverheadMaskIn = 0, txDataEnableIn = 0, rxBitStrobe = 0;
  logic rxDecData = 0, rxOverheadMaskIn = 0, rxFramerOhFlag = 0, losRaw = 0, oofIn = 0;
  logic rxPayloadData = 0, rxPayloadValid = 0, rxSerialReady = 0;
  logic farOn = 0, farP = 0, farN = 0;
  logic rxLinePositive, rxLineNegative, txLinePositive, txLineNegative;
  logic rxDecPositive, rxDecNegative, liuAnalogLoop, txClockFromRx;
  logic txClockLoopTimed, txClockRecovered, txLineData, txDataEnableOut;
  logic txFrameStartToFramer, plbTxData, rxFramerData, rxFramerStrobe;
  logic losStatus, losToFramer, aisDetected, framerRxAis, rxPayloadReady;
  logic rxSerialOut, rxSerialValid, txCellHalt, txCellDiscard, rxLineCellDiscard;
  logic sysLoopbackActive, lbAnalog, lbLine, lbPayload, lbDiag, topPais;
  int mismatches = 0;
  int n_compared = 0;
  int k;
  logic [2:0] system_loopback [7] = '{3'h0, 3'h2, 3'h3, 3'h0, 3'h0, 3'h6, 3'h4};
  // packed as loopback code, line ais code, expected bit
  logic [5:0] laTab [7] = '{6'h03, 6'h06, 6'h00, 6'h21, 6'h30, 6'h12, 6'h05};

  plac_port_ctrl #(.OOF_PERSIST_CYC(OOF_CYC), .AIS_DETECT_BITS(16)) i_plac_port_ctrl (.*);
  plac_line_far_end i_plac_line_far_end (.*);

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [2:0] e, input logic [2:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic loadPais(input logic [2:0] p);
    @(posedge clk);
    cfgLoad <= 1;
    payloadAisSelect <= p;
    @(posedge clk);
    cfgLoad <= 0;
  endtask

  task automatic txbit(input logic d, input logic e);
    @(posedge clk);
    txBitStrobe <= 1;
    txFramerData <= d;
    @(posedge clk);
    txBitStrobe <= 0;
    @(negedge clk);
    chk("txLineData", e, txLineData);
  endtask

  task automatic offer(input logic d, input logic e);
    @(posedge clk);
    rxPayloadValid <= 1;
    rxPayloadData <= d;
    @(negedge clk);
    chk("rxPayloadReady", e, rxPayloadReady);
    @(posedge clk);
    rxPayloadValid <= 0;
  endtask

  task automatic pull(input logic e);
    @(negedge clk);
    chk("rxSerialValid", 1, rxSerialValid);
    chk("rxSerialOut", e, rxSerialOut);
    @(posedge clk);
    rxSerialReady <= 1;
    @(posedge clk);
    rxSerialReady <= 0;
  endtask

  function automatic logic pexp(input int p, input int s);
    logic [4:0] f;
    f = 5'(1 << s) >> 1;
    case (p)
      0: return 1'b1;
      1: return f[0];
      2: return f[1];
      3: return f[0] | f[1];
      4: return f[2];
      5: return f[3];
      6: return |f[3:0];
      default: return 1'b0;
    endcase
  endfunction

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1;
    wt(3);
    chk("topPais", 1, topPais);
    for (int c = 0; c < 8; c++) begin
      @(posedge clk);
      loopbackSelect <= 3'(c);
      systemLoopback <= c[0];
      wt(2);
      chk("lbAnalog", c == 1, lbAnalog);
      chk("lbLine", c == 2 || c == 6, lbLine);
      chk("lbPayload", c == 3, lbPayload);
      chk("lbDiag", c >= 4, lbDiag);
      chk("sysLoopbackActive", c[0], sysLoopbackActive);
      chk("rxLineCellDiscard", c[0], rxLineCellDiscard);
    end
    @(posedge clk);
    systemLoopback <= 0;
    loopbackSelect <= LBS_PAYLOAD;
    plbForceDenZero <= 1;
    txDataEnableIn <= 1;
    txFrameStartIn <= 1;
    framingModeSelect <= FM_DS3;
    wt(6);
    chk("lbPayload", 1, lbPayload);
    chk("txDataEnableOut", 0, txDataEnableOut);
    chk("txFrameStartToFramer", 0, txFrameStartToFramer);
    chk("txCellDiscard", 1, txCellDiscard);
    @(posedge clk);
    plbHaltCells <= 1;
    wt(2);
    chk("txCellHalt", 1, txCellHalt);
    @(posedge clk);
    overheadMaskMode <= 1;
    wt(2);
    chk("lbPayload", 0, lbPayload);
    @(posedge clk);
    overheadMaskMode <= 0;
    loopbackSelect <= 3'h0;
    wt(3);
    chk("txDataEnableOut", 1, txDataEnableOut);
    chk("txFrameStartToFramer", 1, txFrameStartToFramer);
    @(posedge clk);
    txFrameStartIn <= 0;
    loopbackSelect <= LBS_ANALOG;
    txEncPositive <= 1;
    wt(3);
    chk("rxDecPositive", 1, rxDecPositive);
    chk("rxDecNegative", 0, rxDecNegative);
    chk("liuAnalogLoop", 0, liuAnalogLoop);
    @(posedge clk);
    liuEnable <= 1;
    wt(3);
    chk("liuAnalogLoop", 1, liuAnalogLoop);
    chk("txClockRecovered", 1, txClockRecovered);
    @(posedge clk);
    loopTimingEnable <= 1;
    wt(3);
    chk("lbAnalog", 0, lbAnalog);
    chk("liuAnalogLoop", 0, liuAnalogLoop);
    chk("txClockLoopTimed", 1, txClockLoopTimed);
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      loopTimingEnable <= 0;
      liuEnable <= 0;
      farOn <= 1;
      farP <= m[0];
      farN <= !m[0];
      loopbackSelect <= LBS_LINE;
      wt(8);
      chk("txLinePositive", m[0], txLinePositive);
      chk("txLineNegative", !m[0], txLineNegative);
      chk("txClockFromRx", 1, txClockFromRx);
    end
    @(posedge clk);
    farOn <= 0;
    losRaw <= 1;
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      lineCoding <= plac_code_t'(m > 2 ? 2 : m);
      loopbackSelect <= m == 3 ? 3'h4 : 3'h0;
      wt(2);
      chk("losStatus", m >= 2, losStatus);
      chk("losToFramer", m == 2, losToFramer);
    end
    for (int s = 0; s < 7; s++) begin
      for (int p = 0; p < 8; p++) begin
        @(posedge clk);
        loopbackSelect <= system_loopback[s];
        losRaw <= s == 3 || s == 6;
        oofIn <= s == 4;
        cfgLoad <= 1;
        payloadAisSelect <= 3'(p);
        @(posedge clk);
        cfgLoad <= 0;
        wt(3);
        chk("topPais", pexp(p, s), topPais);
      end
    end
    @(posedge clk);
    losRaw <= 0;
    oofIn <= 0;
    loopbackSelect <= 3'h0;
    loadPais(3'h7);
    wt(3);
    // far side stalls: the buffer must hold two words and refuse the third
    offer(1, 1);
    offer(0, 1);
    offer(1, 0);
    pull(1);
    pull(0);
    @(negedge clk);
    chk("rxSerialValid", 0, rxSerialValid);
    loadPais(PAS_ALWAYS);
    wt(3);
    offer(0, 1);
    pull(1);
    @(posedge clk);
    framingModeSelect <= FM_E3;
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      loopbackSelect <= laTab[i][5:3];
      lineAisSelect <= laTab[i][2:1];
      wt(3);
      txbit(0, laTab[i][0]);
    end
    @(posedge clk);
    framingModeSelect <= FM_DS3;
    lineAisSelect <= 2'h3;
    loopbackSelect <= 3'h0;
    txFrameStartIn <= 1;
    wt(4);
    @(posedge clk);
    txFrameStartIn <= 0;
    lineAisSelect <= LAS_SEND; // position aligned before top ais starts
    wt(6);
    txbit(0, 1);
    for (int j = 1; j < 7; j++) begin
      txbit(0, j[0]);
    end
    @(posedge clk);
    lineAisSelect <= 2'h3;
    framingModeSelect <= FM_E3;
    repeat (18) begin
      @(posedge clk);
      rxBitStrobe <= 1;
      rxDecData <= 1;
      @(posedge clk);
      rxBitStrobe <= 0;
    end
    wt(2);
    chk("aisDetected", 1, aisDetected);
    @(posedge clk);
    rxDecData <= 0;
    rxBitStrobe <= 1;
    framerRxAisSw <= 1;
    // one zero bit clears the detector so only software holds framer ais
    @(posedge clk);
    rxBitStrobe <= 0;
    wt(2);
    chk("aisDetected", 0, aisDetected);
    chk("framerRxAis", 1, framerRxAis);
    @(posedge clk);
    framerRxAisSw <= 0;
    framingModeSelect <= FM_DS3;
    oofIn <= 1;
    wt(OOF_CYC - 5);
    chk("framerRxAis", 0, framerRxAis);
    for (k = 0; k < 20 && framerRxAis !== 1'b1; k++) begin
      @(negedge clk);
    end
    chk("framerRxAis", 1, framerRxAis);
    close_out();
  end
endmodule
`default_nettype wire
